// >>> design/lbp_config.sv
// Operation
// RQ1 - Mode code 0100b (reset) sends serial output to the secondary panel and 0110b to the primary.
// RQ2 - Parallel codes 0,1,8,9 target the secondary panel, 2,3,B the primary; others are reserved.
// RQ3 - Software never uses bypass with a 24-bit parallel panel.
// RQ4 - The vertical blank bit reads 1 in the non-display period and 0 in display for an RGB panel.
// RQ5 - The vertical blank bit carries no meaning when the primary panel is not RGB.
// RQ6 - The memory idle bit reads 1 when the memory controller idles and 0 while powered up.
// RQ7 - Software sees memory idle before setting power save or disabling the PLL.
// RQ8 - The pull control bit (reset 1) enables chip-select pull-up and the other pull-downs.
// RQ9 - The pull control acts only on bypass chip select, serial clock, address-zero, serial input.
// RQ10 - Software sets the pull control when the bypass input port is unused.
// RQ11 - The chip-select mode bit matters only while a parallel bypass mode is selected.
// RQ12 - Mode 0 passes bypass select to the panel; mode 1 steers host select by bypass select.
// RQ13 - The power-save bit puts the device in low power at 1 and normal operation at 0.
// RQ14 - The power-save bit resets to 1.
// RQ15 - Software turns off display output and waits for memory idle before power save.
// RQ16 - The bypass enable bit (reset 0) activates the selected route; not while the panel is busy.
// RQ17 - In parallel bypass a direction bit drives the low 18 data pins and pull-downs act on inputs.
`timescale 1ns/1ps
`default_nettype none
module lbp_config
  import lbp_pkg::*;
#(
  parameter int DATA_PINS = 18
)(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [7:0]           i_wb_adr,
  input  wire logic [31:0]          i_wb_dat,
  input  wire logic [3:0]           i_wb_sel,
  output logic      [31:0]          o_wb_dat,
  output logic                      o_wb_ack,
  input  wire logic                 i_primary_panel_rgb,
  input  wire logic                 i_vertical_blank_status,
  input  wire logic                 i_mem_idle,
  input  wire logic                 i_panel_busy,
  input  wire logic                 i_bypass_chip_select_n,
  input  wire logic                 i_host_cs_n,
  output logic                      o_bypass_active,
  output logic                      o_route_primary,
  output logic                      o_route_serial,
  output logic                      o_route_parallel,
  output logic      [3:0]           o_bypass_mode,
  output logic                      o_panel_cs_n,
  output logic                      o_mem_cs_n,
  output logic                      o_in_pull_en,
  output logic      [DATA_PINS-1:0] o_panel_data_bus_oe,
  output logic      [DATA_PINS-1:0] o_panel_data_bus_pd,
  output logic                      o_power_save,
  output logic                      o_irq
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       vb_s;
  logic       mi_s;
  logic       busy_s;
  logic       scs_n_s;
  logic       hcs_n_s;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1_q <= 5'h18;
      sync2_q <= 5'h18;
    end
    else
    begin
      sync1_q <= {i_bypass_chip_select_n, i_host_cs_n, i_panel_busy,
                  i_mem_idle, i_vertical_blank_status};
      sync2_q <= sync1_q;
    end
  end

  assign vb_s    = sync2_q[0];
  assign mi_s    = sync2_q[1];
  assign busy_s  = sync2_q[2];
  assign hcs_n_s = sync2_q[3];
  assign scs_n_s = sync2_q[4];

  // ****************************************
  // Mode decode
  // ****************************************
  function automatic lbp_sel_t decode_mode(input logic en, input logic [3:0] m);
    lbp_sel_t s;
    s = '{active: 1'b0, to_primary: 1'b0, route: LBP_R_NONE};
    if (m == LBP_M_S_SER)
      s = '{active: en, to_primary: 1'b0, route: LBP_R_SERIAL}; // RQ1
    else if (m == LBP_M_P_SER)
      s = '{active: en, to_primary: 1'b1, route: LBP_R_SERIAL}; // RQ1
    else if (m == LBP_M_S_P16 || m == LBP_M_S_P16G || m == LBP_M_S_P8G || m == LBP_M_S_P16H)
      s = '{active: en, to_primary: 1'b0, route: LBP_R_PARALLEL}; // RQ2
    else if (m == LBP_M_P_P16 || m == LBP_M_P_P16G || m == LBP_M_P_P16H)
      s = '{active: en, to_primary: 1'b1, route: LBP_R_PARALLEL}; // RQ2
    if (!en)
      s.route = LBP_R_NONE; // RQ16
    return s;
  endfunction : decode_mode

  // ****************************************
  // Register file
  // ****************************************
  lbp_cfg_t             cfg_q;
  logic [15:0]          cfg_rd;
  logic [LBP_IRQ_W-1:0] stat_q;
  logic [LBP_IRQ_W-1:0] mask_q;
  logic [1:0]           ev_prev_q;
  logic [LBP_IRQ_W-1:0] ev;
  logic                 wr;
  logic                 rd_req;
  logic [15:0]          wd;
  logic [15:0]          cfg_wv;
  lbp_sel_t             sel;

  assign wr     = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  assign rd_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wd     = i_wb_dat[15:0];

  assign cfg_rd = {1'b0, cfg_q.pulldown_en, cfg_q.dir_out, cfg_q.bypass_en, cfg_q.mode,
                   vb_s & i_primary_panel_rgb, mi_s, 1'b0, cfg_q.pull_en,  // RQ4 RQ5 RQ6
                   cfg_q.cs_mode, 2'b00, cfg_q.psave};

  // Byte-lane merge of written config data
  always_comb
  begin
    cfg_wv = cfg_rd;
    if (i_wb_sel[0])
      cfg_wv[7:0] = wd[7:0];
    if (i_wb_sel[1])
      cfg_wv[15:8] = wd[15:8];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      cfg_q <= lbp_cfg_t'({LBP_CFG_RESET[14:8], LBP_CFG_RESET[4:3], LBP_CFG_RESET[0]}); // RQ14 RQ8
    else if (wr && i_wb_adr == LBP_CFG_OFS)
    begin
      cfg_q.pulldown_en <= cfg_wv[LBP_PD_BIT];
      cfg_q.dir_out     <= cfg_wv[LBP_DIR_BIT];
      // Bypass cannot turn on while the panel interface is busy
      cfg_q.bypass_en   <= cfg_wv[LBP_EN_BIT] & (cfg_q.bypass_en | ~busy_s); // RQ16
      cfg_q.mode        <= cfg_wv[LBP_MODE_LSB +: 4];
      cfg_q.pull_en     <= cfg_wv[LBP_PULL_BIT];
      cfg_q.cs_mode     <= cfg_wv[LBP_CSMODE_BIT];
      cfg_q.psave       <= cfg_wv[LBP_PSAVE_BIT]; // RQ13
    end
  end

  // ****************************************
  // Interrupt events
  // ****************************************
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      ev_prev_q <= 2'h0;
    else
      ev_prev_q <= {mi_s, vb_s & i_primary_panel_rgb};
  end

  assign ev[LBP_IRQ_VBLANK] = vb_s & i_primary_panel_rgb & ~ev_prev_q[0];
  assign ev[LBP_IRQ_MIDLE]  = mi_s & ~ev_prev_q[1];

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      stat_q <= '0;
    else if (wr && i_wb_adr == LBP_INT_STAT_OFS && i_wb_sel[0])
      stat_q <= (stat_q & ~wd[LBP_IRQ_W-1:0]) | ev;
    else
      stat_q <= stat_q | ev;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      mask_q <= '0;
    else if (wr && i_wb_adr == LBP_INT_MASK_OFS && i_wb_sel[0])
      mask_q <= wd[LBP_IRQ_W-1:0];
  end

  assign o_irq = |(stat_q & mask_q);

  // ****************************************
  // Bus answer
  // ****************************************
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= rd_req;
      if (rd_req && !i_wb_we)
      begin
        if (i_wb_adr == LBP_CFG_OFS)
          o_wb_dat <= {16'h0000, cfg_rd};
        else if (i_wb_adr == LBP_INT_STAT_OFS)
          o_wb_dat <= {30'h0, stat_q};
        else if (i_wb_adr == LBP_INT_MASK_OFS)
          o_wb_dat <= {30'h0, mask_q};
        else
          o_wb_dat <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  assign sel              = decode_mode(cfg_q.bypass_en, cfg_q.mode);
  assign o_bypass_active  = sel.active;
  assign o_route_primary  = sel.to_primary;
  assign o_route_serial   = (sel.route == LBP_R_SERIAL);
  assign o_route_parallel = (sel.route == LBP_R_PARALLEL);
  assign o_bypass_mode    = cfg_q.mode;
  assign o_power_save     = cfg_q.psave; // RQ13
  assign o_in_pull_en     = cfg_q.pull_en; // RQ8 RQ9

  always_comb
  begin
    o_panel_cs_n = 1'b1;
    o_mem_cs_n   = hcs_n_s;
    if (o_route_parallel) // RQ11
    begin
      if (!cfg_q.cs_mode)
        o_panel_cs_n = scs_n_s; // RQ12
      else if (!scs_n_s)
      begin
        o_panel_cs_n = hcs_n_s; // RQ12
        o_mem_cs_n   = 1'b1;
      end
    end
    else if (o_route_serial)
      o_panel_cs_n = scs_n_s;
  end

  // Direction bit at 0 drives the pins, at 1 makes them inputs
  assign o_panel_data_bus_oe = {DATA_PINS{o_route_parallel & ~cfg_q.dir_out}}; // RQ17
  assign o_panel_data_bus_pd = {DATA_PINS{o_route_parallel & cfg_q.dir_out
                                          & cfg_q.pulldown_en}}; // RQ17

endmodule : lbp_config
`default_nettype wire

// >>> inc/lbp_pkg.sv
`default_nettype none
package lbp_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  LBP_CFG_OFS      = 8'h14;
  localparam logic [7:0]  LBP_INT_STAT_OFS = 8'h40;
  localparam logic [7:0]  LBP_INT_MASK_OFS = 8'h44;

  // ****************************************
  // Field positions of the config register
  // ****************************************
  localparam int LBP_PD_BIT      = 14;
  localparam int LBP_DIR_BIT     = 13;
  localparam int LBP_EN_BIT      = 12;
  localparam int LBP_MODE_LSB    = 8;
  localparam int LBP_VBLANK_BIT  = 7;
  localparam int LBP_MIDLE_BIT   = 6;
  localparam int LBP_PULL_BIT    = 4;
  localparam int LBP_CSMODE_BIT  = 3;
  localparam int LBP_PSAVE_BIT   = 0;

  // Writable bits: 14..8, 4, 3, 0
  localparam logic [15:0] LBP_CFG_WMASK    = 16'h7F19;
  localparam logic [15:0] LBP_CFG_RESET    = 16'h0411;

  // ****************************************
  // Bypass mode codes
  // ****************************************
  localparam logic [3:0] LBP_M_S_P16   = 4'h0;
  localparam logic [3:0] LBP_M_S_P16G  = 4'h1;
  localparam logic [3:0] LBP_M_P_P16   = 4'h2;
  localparam logic [3:0] LBP_M_P_P16G  = 4'h3;
  localparam logic [3:0] LBP_M_S_SER   = 4'h4;
  localparam logic [3:0] LBP_M_P_SER   = 4'h6;
  localparam logic [3:0] LBP_M_S_P8G   = 4'h8;
  localparam logic [3:0] LBP_M_S_P16H  = 4'h9;
  localparam logic [3:0] LBP_M_P_P16H  = 4'hB;

  // Interrupt status bits
  localparam int LBP_IRQ_VBLANK = 0;
  localparam int LBP_IRQ_MIDLE  = 1;
  localparam int LBP_IRQ_W      = 2;

  typedef enum logic [1:0] {LBP_R_NONE, LBP_R_SERIAL, LBP_R_PARALLEL} lbp_route_t;

  typedef struct packed {
    logic       pulldown_en;
    logic       dir_out;
    logic       bypass_en;
    logic [3:0] mode;
    logic       pull_en;
    logic       cs_mode;
    logic       psave;
  } lbp_cfg_t;

  typedef struct packed {
    logic       active;
    logic       to_primary;
    lbp_route_t route;
  } lbp_sel_t;

endpackage : lbp_pkg
`default_nettype wire

// >>> verif/lbp_config_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lbp_config_checker
  import lbp_pkg::*;
#(
  parameter int DATA_PINS = 18
)(
  input wire logic                 i_ref_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack,
  input wire logic [7:0]           i_wb_adr,
  input wire logic [31:0]          i_wb_dat,
  input wire logic [3:0]           i_wb_sel, o_bypass_mode,
  input wire logic                 o_bypass_active, o_route_primary, o_route_serial,
  input wire logic                 o_route_parallel, o_in_pull_en, o_power_save, o_irq,
  input wire logic [DATA_PINS-1:0] o_panel_data_bus_oe, o_panel_data_bus_pd
);
  // ******
  // Checks
  // ******
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  logic wr, lo, hi, rsv, pm;
  assign wr  = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == LBP_CFG_OFS;
  assign lo  = wr && i_wb_sel[0];
  assign hi  = wr && i_wb_sel[1];
  assign rsv = o_bypass_mode inside {4'h5, 4'h7, 4'hA, [4'hC:4'hF]};
  assign pm  = o_bypass_mode inside {4'h2, 4'h3, 4'hB};
  AST_PSAVE: assert property (lo |=> o_power_save == $past(i_wb_dat[0]))
    else $error("power save not written");
  AST_PULL: assert property (lo |=> o_in_pull_en == $past(i_wb_dat[4]))
    else $error("pull enable not written");
  AST_MODE: assert property (hi |=> o_bypass_mode == $past(i_wb_dat[11:8]))
    else $error("mode not written");
  AST_OFF: assert property (hi && !i_wb_dat[12] |=> !o_bypass_active [*2])
    else $error("bypass on after disable");
  AST_RSVD: assert property (rsv |-> !(o_bypass_active | o_route_serial | o_route_parallel))
    else $error("reserved code routed");
  AST_ROUTE: assert property (o_bypass_active == (o_route_serial ^ o_route_parallel))
    else $error("route and active disagree");
  AST_SER: assert property (o_route_serial |-> o_route_primary == (o_bypass_mode == 4'h6))
    else $error("serial panel wrong");
  AST_PAR: assert property (o_route_parallel |-> o_route_primary == pm)
    else $error("parallel panel wrong");
  AST_PD: assert property ((o_panel_data_bus_oe & o_panel_data_bus_pd) == '0)
    else $error("pull-down on driven pin");
  cover property (o_route_parallel && o_route_primary);
  cover property (o_route_serial);
  cover property (o_irq);
endmodule : lbp_config_checker
bind lbp_config lbp_config_checker #(.DATA_PINS(DATA_PINS)) i_lbp_config_checker (.*);
`default_nettype wire

// >>> verif/lbp_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbp_panel_model (
  input  wire logic i_ref_clk, i_rst, i_pull_en, i_drv_en, i_drv_cs_n, i_idle_req,
  output logic      o_vblank, o_mem_idle, o_scs_n
);
  // **************
  // Panel and pins
  // **************
  logic [7:0] ln_q;
  logic [2:0] idle_q;
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
      {ln_q, idle_q} <= '0;
    else
      {ln_q, idle_q} <= {ln_q + 8'h01, idle_q[1:0], i_idle_req};
  assign o_vblank   = ln_q[7];
  assign o_mem_idle = idle_q[2];
  assign o_scs_n    = i_drv_en ? i_drv_cs_n : i_pull_en | ln_q[0];
endmodule : lbp_panel_model
`default_nettype wire

// >>> verif/lbp_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lbp_config_tb
  import lbp_pkg::*;
;
  logic        i_ref_clk = 1'h0, i_rst = 1'h1, i_wb_cyc = 1'h0, i_wb_stb = 1'h0;
  logic        i_wb_we = 1'h0, i_primary_panel_rgb = 1'h0, i_panel_busy = 1'h0;
  logic        i_host_cs_n = 1'h1, drv = 1'h0, drv_cs = 1'h1, idle = 1'h0;
  logic        i_vertical_blank_status, i_mem_idle, i_bypass_chip_select_n, o_wb_ack;
  logic        o_bypass_active, o_route_primary, o_route_serial, o_route_parallel;
  logic        o_panel_cs_n, o_mem_cs_n, o_in_pull_en, o_power_save, o_irq;
  logic [3:0]  i_wb_sel = 4'h3, o_bypass_mode;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [17:0] o_panel_data_bus_oe, o_panel_data_bus_pd;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rnd = 32'h8C3E, mk, exp_q[$], msk_q[$];
  int          miscompares = 0, comparisons = 0;
  // *****
  // Bench
  // *****
  always #5 i_ref_clk = ~i_ref_clk;
  lbp_config i_lbp_config (.*);
  lbp_panel_model i_lbp_panel_model (.i_ref_clk, .i_rst, .i_pull_en(o_in_pull_en),
    .i_drv_en(drv), .i_drv_cs_n(drv_cs), .i_idle_req(idle), .o_vblank(i_vertical_blank_status),
    .o_mem_idle(i_mem_idle), .o_scs_n(i_bypass_chip_select_n));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  task automatic cy(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : cy
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, m);
    int n;
    n = 0;
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, w, a, w ? d : 32'h0};
    cy(1);
    while (o_wb_ack !== 1'h1 && n < 20)
    begin
      cy(1);
      n++;
    end
    miscompares += (n == 20);
    {i_wb_cyc, i_wb_stb} <= 2'h0;
    cy(1);
  endtask : wb
  function automatic logic [2:0] rt(input logic [3:0] m);
    case (m)
      4'h4: return 3'h4;
      4'h6: return 3'h5;
      4'h0, 4'h1, 4'h8, 4'h9: return 3'h2;
      4'h2, 4'h3, 4'hB: return 3'h3;
      default: return 3'h0;
    endcase
  endfunction : rt
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  always @(posedge i_ref_clk)
    if (o_wb_ack === 1'h1 && i_wb_we === 1'h0 && exp_q.size() > 0)
    begin
      mk = msk_q.pop_front();
      chk("read", o_wb_dat & mk, exp_q.pop_front() & mk);
    end
  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end
  initial
  begin
    cy(2);
    i_rst <= 1'h0;
    cy(1);
    chk("reset", {o_power_save, o_in_pull_en, o_irq, o_bypass_mode, o_bypass_active}, 8'hC8);
    wb(0, LBP_CFG_OFS, 32'h0411, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      wb(1, LBP_CFG_OFS, rnd, 0);
      chk("psave", o_power_save, rnd[0]);
      wb(1, 8'h20, ~rnd, 0);
      wb(0, 8'h20, 32'h0, 32'hFFFFFFFF);
      wb(0, LBP_CFG_OFS, {16'h0, rnd[15:0] & LBP_CFG_WMASK}, 32'hFFFFFFFF);
    end
    for (int i = 0; i < 16; i++)
    begin
      wb(1, LBP_CFG_OFS, {20'h1, i[3:0], 8'h00}, 0);
      chk("route", {o_route_serial, o_route_parallel, o_route_primary}, rt(i[3:0]));
    end
    for (int i = 0; i < 8; i++)
    begin
      wb(1, LBP_CFG_OFS, {20'h1, 4'h2, 4'h0, i[2], 3'h0}, 0);
      {drv, drv_cs, i_host_cs_n} <= {1'h1, i[1], i[0]};
      cy(4);
      chk("panel cs", o_panel_cs_n, i[2] ? i[1] | i[0] : i[1]);
      chk("mem cs", o_mem_cs_n, (i[2] & !i[1]) | i[0]);
    end
    for (int i = 0; i < 2; i++)
    begin
      wb(1, LBP_CFG_OFS, {18'h1, i[0], 1'h1, 4'h2, 8'h00}, 0);
      chk("oe", o_panel_data_bus_oe, {18{!i[0]}});
      chk("pd", o_panel_data_bus_pd, {18{i[0]}});
    end
    i_panel_busy <= 1'h1;
    wb(1, LBP_CFG_OFS, 32'h0, 0);
    cy(4);
    wb(1, LBP_CFG_OFS, 32'h1202, 0);
    wb(0, LBP_CFG_OFS, 32'h0, 32'h1000);
    {i_panel_busy, i_primary_panel_rgb} <= 2'h1;
    while (i_vertical_blank_status !== 1'h0)
      cy(1);
    while (i_vertical_blank_status !== 1'h1)
      cy(1);
    cy(4);
    wb(0, LBP_CFG_OFS, 32'h80, 32'h80);
    wb(1, LBP_INT_MASK_OFS, 32'h2, 0);
    idle <= 1'h1;
    cy(8);
    wb(0, LBP_CFG_OFS, 32'h40, 32'h40);
    chk("irq set", o_irq, 1'h1);
    wb(1, LBP_INT_STAT_OFS, 32'h2, 0);
    chk("irq clear", o_irq, 1'h0);
    {idle, i_wb_sel} <= {1'h0, 4'h3};
    wb(1, LBP_INT_MASK_OFS, 32'h0, 0);
    cy(8);
    idle <= 1'h1;
    cy(8);
    chk("irq mask", o_irq, 1'h0);
    wb(1, LBP_INT_MASK_OFS, 32'h2, 0);
    chk("irq unmask", o_irq, 1'h1);
    wb(1, LBP_CFG_OFS, 32'h11, 0);
    chk("psave on", o_power_save, 1'h1);
    conclude();
  end
endmodule : lbp_config_tb
`default_nettype wire
